// ---- src/pbw_ctrl.sv ----
/*
 * Power switch and wake controller for the always-on standby domain.
 * Tracks the system state, times the power switch, gathers wake sources,
 * applies the AC-return policy, drives rail enables and standby lamp.
 * Assumes all inputs are synchronous to mclk except the raw switch,
 * which is synchronised and debounced here.
 */
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps

module pbw_ctrl
#(
    parameter logic [29:0] FOUR_CYC = pbw_pkg::FOUR_CYC,
    parameter logic [29:0] SIX_CYC  = pbw_pkg::SIX_CYC,
    parameter logic [29:0] DEB_CYC  = pbw_pkg::DEB_CYC
)
(
    input  wire logic               mclk,
    input  wire logic               nrst,
    input  wire logic               pwr_sw_n,
    input  wire pbw_pkg::pbw_wake_t wake_in,
    input  wire logic               ac_ok,
    input  wire logic               os_sleep_req,
    input  wire logic [1:0]         os_sleep_type,
    input  wire logic               os_deep,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    output pbw_pkg::pbw_state_t     sys_state,
    output pbw_pkg::pbw_pwr_t       pwr_en,
    output logic                    sleep_req,
    output logic                    cold_boot,
    output logic                    stby_led
);

    logic                sync1_q;
    logic                sync2_q;
    logic                deb_q;
    logic [29:0]         deb_cnt_q;
    logic [29:0]         press_cnt_q;
    logic                rel_short;
    logic                force_evt;
    logic                cec_q;
    logic                press_evt;
    logic [1:0]          pol_q;
    logic                usb45_en_q;
    logic                g3_seen_q;
    logic                deep_q;
    logic                last_on_q;
    pbw_pkg::pbw_state_t state_q;
    pbw_pkg::pbw_state_t state_d;
    pbw_pkg::pbw_wake_t  armed;
    pbw_pkg::pbw_wake_t  wake_src_q;
    pbw_pkg::pbw_pwr_t   pwr_q;
    logic                sleep_req_q;
    logic                cold_boot_q;
    logic                led_q;
    logic [31:0]         rdata_q;

    // which wake sources may act in a given state
    function automatic pbw_pkg::pbw_wake_t wake_mask(
        input pbw_pkg::pbw_state_t st,
        input logic                g3,
        input logic                deep,
        input logic                usb45
    );
        pbw_pkg::pbw_wake_t m;
        m = '0;
        if (st == pbw_pkg::ST_S3 || st == pbw_pkg::ST_S4
            || st == pbw_pkg::ST_S5)
        begin
            m.pwr  = 1'b1;
            m.rtc  = 1'b1;
            m.lan  = 1'b1;
            m.wlan = 1'b1;
            m.cec  = 1'b1;
            m.bt   = (st == pbw_pkg::ST_S3);
            if (st == pbw_pkg::ST_S3)
            begin
                m.usb = !g3;
            end
            else
            begin
                m.usb = usb45 && !g3 && !deep;
            end
            m.serial = 1'b0;
        end
        return m;
    endfunction

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= pwr_sw_n;
            sync2_q <= sync1_q;
        end
    end

    // debounce: level must hold a full window before it is believed
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            deb_q     <= 1'b0;
            deb_cnt_q <= '0;
        end
        else if ((!sync2_q) == deb_q)
        begin
            deb_cnt_q <= '0;
        end
        else if (deb_cnt_q >= DEB_CYC - 30'h1)
        begin
            deb_q     <= !sync2_q;
            deb_cnt_q <= '0;
        end
        else
        begin
            deb_cnt_q <= deb_cnt_q + 30'h1;
        end
    end

    // press timer saturates at six seconds so a long hold fires once
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            press_cnt_q <= '0;
        end
        else if (!deb_q)
        begin
            press_cnt_q <= '0;
        end
        else if (press_cnt_q < SIX_CYC)
        begin
            press_cnt_q <= press_cnt_q + 30'h1;
        end
    end

    // forced off fires while held; anything shorter acts on release
    assign force_evt = deb_q && (press_cnt_q == SIX_CYC - 30'h1);
    assign rel_short = !deb_q && (press_cnt_q != '0)
                       && (press_cnt_q < SIX_CYC);

    // cec request edge, merged with a brief switch press
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            cec_q <= 1'b0;
        end
        else
        begin
            cec_q <= wake_in.cec;
        end
    end

    assign press_evt = rel_short || (wake_in.cec && !cec_q);

    assign armed = wake_in & wake_mask(state_q, g3_seen_q, deep_q,
                                       usb45_en_q);

    // next system state; loss of AC overrides everything
    always_comb
    begin
        state_d = state_q;
        if (!ac_ok)
        begin
            state_d = pbw_pkg::ST_G3;
        end
        else
        begin
            unique case (state_q)
                pbw_pkg::ST_G3:
                begin
                    if (pol_q == pbw_pkg::POL_ON
                        || (pol_q == pbw_pkg::POL_LAST && last_on_q))
                    begin
                        state_d = pbw_pkg::ST_WORK;
                    end
                    else
                    begin
                        state_d = pbw_pkg::ST_S5;
                    end
                end
                pbw_pkg::ST_WORK:
                begin
                    if (force_evt)
                    begin
                        state_d = pbw_pkg::ST_S5;
                    end
                    else if (os_sleep_req)
                    begin
                        unique case (os_sleep_type)
                            pbw_pkg::SLP_S3: state_d = pbw_pkg::ST_S3;
                            pbw_pkg::SLP_S4: state_d = pbw_pkg::ST_S4;
                            default:         state_d = pbw_pkg::ST_S5;
                        endcase
                    end
                end
                pbw_pkg::ST_S3, pbw_pkg::ST_S4:
                begin
                    if (force_evt)
                    begin
                        state_d = pbw_pkg::ST_S5;
                    end
                    else if (press_evt || armed != '0)
                    begin
                        state_d = pbw_pkg::ST_WORK;
                    end
                end
                pbw_pkg::ST_S5:
                begin
                    // lan covers wake-pattern frames from the network side
                    if (press_evt || armed != '0)
                    begin
                        state_d = pbw_pkg::ST_WORK;
                    end
                end
                default:
                begin
                    state_d = pbw_pkg::ST_G3;
                end
            endcase
        end
    end

    // state, plus memory of what held before AC was lost
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q   <= pbw_pkg::ST_G3;
            g3_seen_q <= 1'b1;
            last_on_q <= 1'b0;
            deep_q    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (!ac_ok && state_q != pbw_pkg::ST_G3)
            begin
                last_on_q <= (state_q == pbw_pkg::ST_WORK);
            end
            // usb arming is lost by AC loss until the system runs again
            if (state_d == pbw_pkg::ST_G3)
            begin
                g3_seen_q <= 1'b1;
            end
            else if (state_d == pbw_pkg::ST_WORK)
            begin
                g3_seen_q <= 1'b0;
            end
            if (state_q == pbw_pkg::ST_WORK && os_sleep_req)
            begin
                deep_q <= os_deep;
            end
        end
    end

    // rails follow the next state so they change with the state itself
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwr_q <= '0;
        end
        else
        begin
            pwr_q.cpu  <= (state_d == pbw_pkg::ST_WORK);
            pwr_q.dev  <= (state_d == pbw_pkg::ST_WORK);
            pwr_q.mem  <= (state_d == pbw_pkg::ST_WORK)
                          || (state_d == pbw_pkg::ST_S3);
            pwr_q.wake <= (state_d != pbw_pkg::ST_G3);
        end
    end

    // one-cycle notices to the operating system and the boot logic
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleep_req_q <= 1'b0;
            cold_boot_q <= 1'b0;
        end
        else
        begin
            sleep_req_q <= ac_ok && state_q == pbw_pkg::ST_WORK
                           && press_evt && !force_evt;
            cold_boot_q <= state_d == pbw_pkg::ST_WORK
                           && (state_q == pbw_pkg::ST_S5
                               || state_q == pbw_pkg::ST_G3);
        end
    end

    // standby lamp tracks standby power only
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            led_q <= 1'b0;
        end
        else
        begin
            led_q <= ac_ok;
        end
    end

    // control register and last wake source capture
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pol_q      <= pbw_pkg::POL_RST;
            usb45_en_q <= pbw_pkg::USB45_RST;
            wake_src_q <= '0;
        end
        else
        begin
            if (reg_wr && reg_addr == pbw_pkg::CTRL_OFF)
            begin
                pol_q      <= reg_wdata[pbw_pkg::CTRL_POL_LSB +: 2];
                usb45_en_q <= reg_wdata[pbw_pkg::CTRL_USB45_BIT];
            end
            if (state_q != pbw_pkg::ST_WORK && state_d == pbw_pkg::ST_WORK)
            begin
                wake_src_q     <= armed;
                wake_src_q.pwr <= armed.pwr || rel_short;
            end
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= '0;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    pbw_pkg::CTRL_OFF:
                    begin
                        rdata_q[pbw_pkg::CTRL_POL_LSB +: 2] <= pol_q;
                        rdata_q[pbw_pkg::CTRL_USB45_BIT]    <= usb45_en_q;
                    end
                    pbw_pkg::STAT_OFF:
                    begin
                        rdata_q[pbw_pkg::STAT_ST_LSB +: 3]  <= state_q;
                        rdata_q[pbw_pkg::STAT_G3_BIT]       <= g3_seen_q;
                        rdata_q[pbw_pkg::STAT_DEEP_BIT]     <= deep_q;
                        rdata_q[pbw_pkg::STAT_SW_BIT]       <= deb_q;
                        rdata_q[pbw_pkg::STAT_MID_BIT]      <=
                            press_cnt_q >= FOUR_CYC;
                    end
                    pbw_pkg::WAKE_OFF:
                    begin
                        rdata_q[7:0] <= wake_src_q;
                    end
                    default:
                    begin
                        rdata_q <= '0;
                    end
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign sys_state = state_q;
    assign pwr_en    = pwr_q;
    assign sleep_req = sleep_req_q;
    assign cold_boot = cold_boot_q;
    assign stby_led  = led_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    soft_off_wake_a: assert property (
        state_q == pbw_pkg::ST_S5 && ac_ok && press_evt
        |=> state_q == pbw_pkg::ST_WORK ##0 cold_boot_q)
        else $error("short press in soft off did not power on");
    sleep_request_a: assert property (
        state_q == pbw_pkg::ST_WORK && ac_ok && press_evt && !force_evt
        |=> sleep_req_q ##1 !sleep_req_q)
        else $error("short press while working gave no sleep request");
    force_off_a: assert property (
        state_q == pbw_pkg::ST_WORK && ac_ok && deb_q
        && press_cnt_q == SIX_CYC - 30'h1
        |=> state_q == pbw_pkg::ST_S5 && !pwr_q.cpu)
        else $error("six second hold did not force soft off");
    sleep_wake_a: assert property (
        (state_q == pbw_pkg::ST_S3 || state_q == pbw_pkg::ST_S4)
        && ac_ok && press_evt && !force_evt
        |=> state_q == pbw_pkg::ST_WORK && pwr_q.cpu)
        else $error("short press did not wake from sleep");
    sleep_force_a: assert property (
        state_q == pbw_pkg::ST_S3 && ac_ok && force_evt
        |=> state_q == pbw_pkg::ST_S5 && !pwr_q.mem)
        else $error("long hold in sleep did not reach soft off");
    serial_ignore_a: assert property (
        state_q == pbw_pkg::ST_S3 && ac_ok && !press_evt && !force_evt
        && wake_in == pbw_pkg::pbw_wake_t'(8'h80)
        |=> state_q == pbw_pkg::ST_S3)
        else $error("serial activity woke the system");
    usb_deep_a: assert property (
        state_q == pbw_pkg::ST_S4 && deep_q |-> !armed.usb)
        else $error("usb armed in deep suspend to disk");
    usb_after_g3_a: assert property (
        state_q == pbw_pkg::ST_S3 && ac_ok && !g3_seen_q && wake_in.usb
        |=> state_q == pbw_pkg::ST_WORK)
        else $error("usb activity did not wake suspend to ram");
    lan_after_g3_a: assert property (
        state_q == pbw_pkg::ST_S5 && ac_ok && g3_seen_q && wake_in.lan
        |=> state_q == pbw_pkg::ST_WORK)
        else $error("network wake lost after AC loss");
    ac_policy_a: assert property (
        state_q == pbw_pkg::ST_G3 && ac_ok && pol_q == pbw_pkg::POL_OFF
        |=> state_q == pbw_pkg::ST_S5 ##1 !pwr_q.cpu)
        else $error("stay off policy not honoured");
    rails_sleep_a: assert property (
        state_q inside {pbw_pkg::ST_S3, pbw_pkg::ST_S4, pbw_pkg::ST_S5}
        |-> !pwr_q.cpu && !pwr_q.dev && pwr_q.wake)
        else $error("rails wrong while sleeping");
    lamp_standby_a: assert property (
        $rose(ac_ok) |=> stby_led)
        else $error("standby lamp dark with standby power");

    cov_force_c: cover property (force_evt && state_q == pbw_pkg::ST_WORK);
    cov_s3_wake_c: cover property (
        state_q == pbw_pkg::ST_S3 ##1 state_q == pbw_pkg::ST_WORK);
    cov_ac_last_c: cover property (
        state_q == pbw_pkg::ST_G3 && ac_ok && last_on_q);

endmodule

// ---- src/pbw_pkg.sv ----
/*
 * Shared definitions for the power switch and wake controller: timing
 * constants, register offsets and fields, system states, wake sources.
 * Assumes a single always-on standby clock of 100 MHz.
 */
package pbw_pkg;

    // clock and press timing, each time in its own unit
    localparam int unsigned CLK_HZ    = 100_000_000;
    localparam int unsigned FOUR_S    = 4;
    localparam int unsigned SIX_S     = 6;
    localparam int unsigned DEB_MS    = 10;
    localparam int unsigned CNT_W     = 30;
    localparam logic [29:0] FOUR_CYC  = 30'(FOUR_S * CLK_HZ);
    localparam logic [29:0] SIX_CYC   = 30'(SIX_S * CLK_HZ);
    localparam logic [29:0] DEB_CYC   = 30'(DEB_MS * (CLK_HZ / 1000));

    // register map, byte addresses
    localparam logic [3:0]  CTRL_OFF  = 4'h0;
    localparam logic [3:0]  STAT_OFF  = 4'h4;
    localparam logic [3:0]  WAKE_OFF  = 4'h8;

    // control register fields and reset values
    localparam int unsigned CTRL_POL_LSB   = 0;
    localparam int unsigned CTRL_USB45_BIT = 2;
    localparam logic [1:0]  POL_ON    = 2'h0;
    localparam logic [1:0]  POL_OFF   = 2'h1;
    localparam logic [1:0]  POL_LAST  = 2'h2;
    localparam logic [1:0]  POL_RST   = 2'h2;
    localparam logic        USB45_RST = 1'h0;

    // status register field positions
    localparam int unsigned STAT_ST_LSB  = 0;
    localparam int unsigned STAT_G3_BIT  = 3;
    localparam int unsigned STAT_DEEP_BIT = 4;
    localparam int unsigned STAT_SW_BIT  = 5;
    localparam int unsigned STAT_MID_BIT = 6;

    // sleep request types from the operating system
    localparam logic [1:0]  SLP_S3    = 2'h0;
    localparam logic [1:0]  SLP_S4    = 2'h1;

    typedef enum logic [2:0] {
        ST_WORK,
        ST_S3,
        ST_S4,
        ST_S5,
        ST_G3
    } pbw_state_t;

    // wake sources, one bit each
    typedef struct packed {
        logic serial;
        logic cec;
        logic usb;
        logic bt;
        logic wlan;
        logic lan;
        logic rtc;
        logic pwr;
    } pbw_wake_t;

    // rail enables
    typedef struct packed {
        logic cpu;
        logic dev;
        logic mem;
        logic wake;
    } pbw_pwr_t;

endpackage

// ---- test/pbw_partner.sv ----
/*
 * Far-side model: a power switch whose contacts chatter, and an operating
 * system that answers a sleep request after os_lat cycles.
 * Assumes mclk from the bench; every change lands just after a rising edge.
 */
`timescale 1ns/1ps

module pbw_partner
(
    input  wire logic  mclk,
    input  wire logic  sleep_req,
    output logic       pwr_sw_n,
    output logic       os_sleep_req,
    output logic [1:0] os_sleep_type,
    output logic       os_deep
);
    int os_lat = 3;

    // switch open, no sleep entry, idle fields hold no stale request
    initial
    begin
        pwr_sw_n      = 1'h1;
        os_sleep_req  = 1'h0;
        os_sleep_type = 2'h3;
        os_deep       = 1'h1;
    end

    // chatter on make and break, n+1 cycles firmly closed in between
    task automatic press(input int n);
        @(posedge mclk) pwr_sw_n <= 1'h0;
        @(posedge mclk) pwr_sw_n <= 1'h1;
        @(posedge mclk) pwr_sw_n <= 1'h0;
        repeat (n) @(posedge mclk);
        @(posedge mclk) pwr_sw_n <= 1'h1;
        @(posedge mclk) pwr_sw_n <= 1'h0;
        @(posedge mclk) pwr_sw_n <= 1'h1;
    endtask

    // one-cycle sleep entry; fields inverted afterwards so none is reused
    task automatic enter(input logic [1:0] ty, input logic deep);
        @(posedge mclk);
        os_sleep_req  <= 1'h1;
        os_sleep_type <= ty;
        os_deep       <= deep;
        @(posedge mclk);
        os_sleep_req  <= 1'h0;
        os_sleep_type <= ~ty;
        os_deep       <= ~deep;
    endtask

    // os settings: a switch-driven sleep request enters suspend-to-ram
    always @(posedge mclk)
    begin
        if (sleep_req)
        begin
            repeat (os_lat) @(posedge mclk);
            enter(pbw_pkg::SLP_S3, 1'h0);
        end
    end
endmodule

// ---- test/power_button_wake_control_test.sv ----
/*
 * Self-checking bench for the power switch and wake controller: a table
 * of wake cases, then switch timing, ac return policy and registers.
 * Assumes shortened press counts and the partner model beside the design.
 */
`timescale 1ns/1ps

`define CHK(a, e) \
    begin \
        total_checks++; \
        if ((a) !== (e)) \
        begin \
            n_fail++; \
            $display("Error at %0t: got %h expected %h", $time, a, e); \
        end \
    end

module power_button_wake_control_test;
    typedef struct packed {
        logic [1:0] ty;
        logic       deep;
        logic       usb;
        logic [7:0] w;
        logic [2:0] slp;
        logic [2:0] exp;
    } pbw_row_t;

    logic                mclk;
    logic                nrst;
    logic                pwr_sw_n;
    pbw_pkg::pbw_wake_t  wake_in;
    logic                ac_ok;
    logic                os_sleep_req;
    logic [1:0]          os_sleep_type;
    logic                os_deep;
    logic [3:0]          reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [31:0]         reg_rdata;
    pbw_pkg::pbw_state_t sys_state;
    pbw_pkg::pbw_pwr_t   pwr_en;
    logic                sleep_req;
    logic                cold_boot;
    logic                stby_led;
    int                  n_fail;
    int                  total_checks;
    pbw_row_t            rows [14];
    logic [1:0]          pol [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    logic [2:0]          pexp [4] = '{3'h0, 3'h0, 3'h3, 3'h3};

    // short counts keep the run brief: 4 s = 40, 6 s = 60, debounce 4
    pbw_ctrl #(.FOUR_CYC(30'h28), .SIX_CYC(30'h3C), .DEB_CYC(30'h4))
    pbw_ctrl_i
    (
        .mclk          (mclk),
        .nrst          (nrst),
        .pwr_sw_n      (pwr_sw_n),
        .wake_in       (wake_in),
        .ac_ok         (ac_ok),
        .os_sleep_req  (os_sleep_req),
        .os_sleep_type (os_sleep_type),
        .os_deep       (os_deep),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .sys_state     (sys_state),
        .pwr_en        (pwr_en),
        .sleep_req     (sleep_req),
        .cold_boot     (cold_boot),
        .stby_led      (stby_led)
    );

    pbw_partner pbw_partner_i
    (
        .mclk          (mclk),
        .sleep_req     (sleep_req),
        .pwr_sw_n      (pwr_sw_n),
        .os_sleep_req  (os_sleep_req),
        .os_sleep_type (os_sleep_type),
        .os_deep       (os_deep)
    );

    // 100 MHz clock
    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'h0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'h0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    // bounded wait, sampling clear of the edge so no race decides it
    task automatic wait_st(input logic [2:0] e, input int lim);
        #1;
        for (int i = 0; i < lim && sys_state !== e; i++)
            @(posedge mclk) #1;
        `CHK(sys_state, e)
    endtask

    task automatic tap(input logic [2:0] e);
        pbw_partner_i.press(20);
        wait_st(e, 40);
    endtask

    task automatic poke(input logic [7:0] w, input logic [2:0] e);
        @(posedge mclk);
        wake_in <= w;
        repeat (2) @(posedge mclk);
        wake_in <= 8'h00;
        wait_st(e, 2);
    endtask

    // force must land while the switch is still held, release adds nothing
    task automatic long_press();
        fork
            pbw_partner_i.press(100);
        join_none
        wait_st(3'h3, 90);
        rd_chk(pbw_pkg::STAT_OFF, 32'h63);
        repeat (60) @(posedge mclk);
        #1;
        `CHK(sys_state, 3'h3)
    endtask

    function automatic logic [3:0] rails(input logic [2:0] s);
        case (s)
            3'h0:    return 4'hF;
            3'h1:    return 4'h3;
            3'h4:    return 4'h0;
            default: return 4'h1;
        endcase
    endfunction

    // watchdog: generous span for under 1000 cycles of tests
    initial
    begin
        #300000;
        n_fail++;
        give_verdict();
    end

    // main sequence: reset, registers, wake table, then awkward cases
    initial
    begin
        rows = '{
            '{2'h0, 1'h0, 1'h0, 8'h02, 3'h1, 3'h0},
            '{2'h0, 1'h0, 1'h0, 8'h10, 3'h1, 3'h0},
            '{2'h1, 1'h0, 1'h0, 8'h10, 3'h2, 3'h2},
            '{2'h0, 1'h0, 1'h0, 8'h80, 3'h1, 3'h1},
            '{2'h3, 1'h0, 1'h1, 8'h80, 3'h3, 3'h3},
            '{2'h2, 1'h0, 1'h0, 8'h04, 3'h3, 3'h0},
            '{2'h1, 1'h0, 1'h0, 8'h08, 3'h2, 3'h0},
            '{2'h1, 1'h0, 1'h0, 8'h20, 3'h2, 3'h2},
            '{2'h1, 1'h0, 1'h1, 8'h20, 3'h2, 3'h0},
            '{2'h2, 1'h1, 1'h1, 8'h20, 3'h3, 3'h3},
            '{2'h1, 1'h1, 1'h1, 8'h20, 3'h2, 3'h2},
            '{2'h0, 1'h0, 1'h0, 8'h20, 3'h1, 3'h0},
            '{2'h2, 1'h0, 1'h0, 8'h40, 3'h3, 3'h0},
            '{2'h0, 1'h0, 1'h0, 8'h01, 3'h1, 3'h0}
        };
        nrst         = 1'h0;
        ac_ok        = 1'h1;
        wake_in      = 8'h00;
        reg_addr     = 4'h0;
        reg_wdata    = 32'h0;
        reg_wr       = 1'h0;
        reg_rd       = 1'h0;
        n_fail       = 0;
        total_checks = 0;
        repeat (12) @(posedge mclk);
        nrst <= 1'h1;
        wait_st(3'h3, 3);
        `CHK(pwr_en, 4'h1)
        `CHK(stby_led, 1'h1)
        rd_chk(pbw_pkg::CTRL_OFF, 32'h2);
        rd_chk(pbw_pkg::STAT_OFF, 32'hB);
        wr(pbw_pkg::STAT_OFF, 32'hFF);
        rd_chk(pbw_pkg::STAT_OFF, 32'hB);
        rd_chk(4'hC, 32'h0);
        pbw_partner_i.press(0);
        repeat (20) @(posedge mclk);
        wait_st(3'h3, 1);
        tap(3'h0);
        `CHK(cold_boot, 1'h1)
        foreach (rows[k])
        begin
            wr(pbw_pkg::CTRL_OFF, {29'h0, rows[k].usb, pbw_pkg::POL_LAST});
            pbw_partner_i.enter(rows[k].ty, rows[k].deep);
            wait_st(rows[k].slp, 5);
            poke(rows[k].w, rows[k].exp);
            `CHK(pwr_en, rails(rows[k].exp))
            if (rows[k].exp !== 3'h0)
                tap(3'h0);
        end
        tap(3'h1);
        tap(3'h0);
        long_press();
        pbw_partner_i.press(50);
        wait_st(3'h0, 40);
        pbw_partner_i.enter(pbw_pkg::SLP_S3, 1'h0);
        long_press();
        for (int p = 0; p < 4; p++)
        begin
            wr(pbw_pkg::CTRL_OFF, {30'h0, pol[p]});
            ac_ok <= 1'h0;
            wait_st(3'h4, 3);
            `CHK(pwr_en, 4'h0)
            @(posedge mclk);
            #1;
            `CHK(stby_led, 1'h0)
            @(posedge mclk);
            ac_ok <= 1'h1;
            wait_st(pexp[p], 3);
        end
        wr(pbw_pkg::CTRL_OFF, 32'h5);
        poke(8'h20, 3'h3);
        poke(8'h04, 3'h0);
        rd_chk(pbw_pkg::WAKE_OFF, 32'h4);
        // reset in mid-run must drop the written policy back to last state
        nrst <= 1'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        wait_st(3'h3, 3);
        `CHK(pwr_en, 4'h1)
        rd_chk(pbw_pkg::CTRL_OFF, 32'h2);
        give_verdict();
    end
endmodule
